// ---- hw/arp_defines.svh ----
`ifndef ARP_DEFINES_SVH
`define ARP_DEFINES_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define ARP_WORD_W 16
`define ARP_DATA_W 14
`define ARP_ADDR_HI 15
`define ARP_ADDR_LO 14

// ----------------------------------------
// write address codes
// ----------------------------------------
`define ARP_WADDR_NONE 2'h0
`define ARP_WADDR_TEST 2'h1
`define ARP_WADDR_CAL 2'h2
`define ARP_WADDR_CTRL 2'h3

// ----------------------------------------
// control field positions
// ----------------------------------------
`define ARP_CTL_INPUT_CONFIG 13
`define ARP_CTL_CHAN_HI 12
`define ARP_CTL_CHAN_LO 10
`define ARP_CTL_POWER_HI 9
`define ARP_CTL_POWER_LO 8
`define ARP_CTL_RDSEL_HI 7
`define ARP_CTL_RDSEL_LO 6
`define ARP_CTL_RANGE 5
`define ARP_CTL_CONV_START 4
`define ARP_CTL_CAL_TYPE 3
`define ARP_CTL_CALSEL_HI 2
`define ARP_CTL_CALSEL_LO 1
`define ARP_CTL_CAL_START 0
`define ARP_CTL_RESET 14'h0000

// ----------------------------------------
// read select codes
// ----------------------------------------
`define ARP_RSEL_RESULT 2'h0
`define ARP_RSEL_TEST 2'h1
`define ARP_RSEL_CAL 2'h2
`define ARP_RSEL_STATUS 2'h3

// ----------------------------------------
// host register map (axi4-lite)
// ----------------------------------------
`define ARP_HOST_WRITE 4'h0
`define ARP_HOST_READ 4'h4
`define ARP_HOST_STATUS 4'h8
`define ARP_HOST_DATA 4'hc
`define ARP_AXI_OKAY 2'h0
`define ARP_AXI_SLVERR 2'h2

`endif

// ---- hw/arp_pkg.sv ----
package arp_pkg;
  typedef enum logic [1:0]
  {
    ARP_HS_IDLE = 2'b00,
    ARP_HS_LOW = 2'b01,
    ARP_HS_HIGH = 2'b10
  } arp_host_state_type;
endpackage

// ---- hw/arp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface arp_if;
  logic word_mode;
  logic [15:0] data_from_host;
  logic [15:0] data_to_host;
  logic wr_strobe;
  logic rd_strobe;
  modport device
  (
    input word_mode,
    input data_from_host,
    input wr_strobe,
    input rd_strobe,
    output data_to_host
  );
  modport host
  (
    output word_mode,
    output data_from_host,
    output wr_strobe,
    output rd_strobe,
    input data_to_host
  );
endinterface
`default_nettype wire

// ---- hw/arp_device.sv ----
`include "arp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module arp_device
(
  input wire logic aclk,
  input wire logic aresetn,
  arp_if.device link,
  input wire logic sleep_n,
  input wire logic [11:0] conv_result,
  input wire logic [13:0] conv_status,
  input wire logic conv_done,
  input wire logic cal_done,
  output logic conv_start_pulse,
  output logic cal_start_pulse,
  output logic cal_type_select,
  output logic [1:0] cal_index,
  output logic input_config_select,
  output logic [2:0] channel_select,
  output logic analog_range_select,
  output logic [2:0] power_mode
);
  typedef struct packed
  {
    logic [13:0] ctrl;
    logic [13:0] test;
    logic [3:0][13:0] cal;
    logic [7:0] low_byte;
    logic conv_busy;
    logic cal_busy;
    logic [15:0] rdata;
    logic conv_go;
    logic cal_go;
  } arp_dev_state_type;

  arp_dev_state_type s_reg;
  arp_dev_state_type s_next;
  logic [15:0] word;
  logic commit;
  logic [13:0] wdata;
  logic [1:0] rsel;
  logic [1:0] csel;

  // ----------------------------------------
  // write assembly and register update
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.conv_go = 1'b0;
    s_next.cal_go = 1'b0;
    word = link.data_from_host;
    commit = 1'b0;
    if (link.wr_strobe)
    begin
      if (link.word_mode)
        commit = 1'b1;
      else if (!link.data_from_host[8])
        s_next.low_byte = link.data_from_host[7:0];
      else
      begin
        word = {link.data_from_host[7:0], s_reg.low_byte};
        commit = 1'b1;
      end
    end
    wdata = word[`ARP_DATA_W-1:0];
    csel = s_reg.ctrl[`ARP_CTL_CALSEL_HI:`ARP_CTL_CALSEL_LO];
    if (s_reg.conv_busy && conv_done)
    begin
      s_next.conv_busy = 1'b0;
      s_next.ctrl[`ARP_CTL_CONV_START] = 1'b0;
    end
    if (s_reg.cal_busy && cal_done)
      s_next.cal_busy = 1'b0;
    if (commit)
    begin
      unique case (word[`ARP_ADDR_HI:`ARP_ADDR_LO])
        `ARP_WADDR_NONE:
          s_next.ctrl = s_next.ctrl;
        `ARP_WADDR_TEST:
          s_next.test = wdata;
        `ARP_WADDR_CAL:
          if (!s_reg.ctrl[`ARP_CTL_CAL_START])
            s_next.cal[csel] = wdata;
        `ARP_WADDR_CTRL:
        begin
          s_next.ctrl = wdata;
          if (wdata[`ARP_CTL_CONV_START])
          begin
            s_next.conv_busy = 1'b1;
            s_next.conv_go = 1'b1;
          end
          if (wdata[`ARP_CTL_CAL_START])
          begin
            s_next.cal_busy = 1'b1;
            s_next.cal_go = 1'b1;
          end
        end
      endcase
    end
    rsel = s_reg.ctrl[`ARP_CTL_RDSEL_HI:`ARP_CTL_RDSEL_LO];
    unique case (rsel)
      `ARP_RSEL_RESULT:
        s_next.rdata = {4'h0, conv_result};
      `ARP_RSEL_TEST:
        s_next.rdata = {2'h0, s_reg.test};
      `ARP_RSEL_CAL:
        s_next.rdata = {2'h0, s_reg.cal[csel]};
      `ARP_RSEL_STATUS:
        s_next.rdata = {2'h0, conv_status};
    endcase
    if (!aresetn)
    begin
      s_next = '0;
      s_next.ctrl = `ARP_CTL_RESET;
    end
  end

  always_ff @(posedge aclk)
    s_reg <= s_next;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb
  begin
    // byte mode reads: line 8 picks half
    if (link.word_mode)
      link.data_to_host = s_reg.rdata;
    else if (link.data_from_host[8])
      link.data_to_host = {8'h00, s_reg.rdata[15:8]};
    else
      link.data_to_host = {8'h00, s_reg.rdata[7:0]};
  end

  assign conv_start_pulse = s_reg.conv_go;
  assign cal_start_pulse = s_reg.cal_go;
  assign cal_type_select = s_reg.ctrl[`ARP_CTL_CAL_TYPE];
  assign cal_index = s_reg.ctrl[`ARP_CTL_CALSEL_HI:`ARP_CTL_CALSEL_LO];
  assign input_config_select = s_reg.ctrl[`ARP_CTL_INPUT_CONFIG];
  assign channel_select =
    s_reg.ctrl[`ARP_CTL_CHAN_HI:`ARP_CTL_CHAN_LO];
  assign analog_range_select = s_reg.ctrl[`ARP_CTL_RANGE];
  assign power_mode =
    {s_reg.ctrl[`ARP_CTL_POWER_HI:`ARP_CTL_POWER_LO], sleep_n};
endmodule
`default_nettype wire

// ---- hw/arp_host.sv ----
`include "arp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module arp_host
(
  input wire logic aclk,
  input wire logic aresetn,
  arp_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed
  {
    arp_pkg::arp_host_state_type st;
    logic [15:0] word;
    logic word_mode;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] last_read;
    logic [15:0] pin_data;
    logic wr;
    logic rd;
    logic rd_pend;
  } arp_host_s_type;

  arp_host_s_type s_reg;
  arp_host_s_type s_next;
  logic busy;

  // ----------------------------------------
  // axi slave and link sequencer
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    busy = s_reg.st != arp_pkg::ARP_HS_IDLE;
    if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
    end
    if (s_reg.aw_got && s_reg.w_got && !busy)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `ARP_AXI_OKAY;
      unique case (s_reg.awaddr)
        `ARP_HOST_WRITE:
        begin
          s_next.word = s_reg.wdata[15:0];
          s_next.word_mode = s_reg.wdata[16];
          s_next.st = arp_pkg::ARP_HS_LOW;
        end
        `ARP_HOST_READ:
        begin
          s_next.word_mode = s_reg.wdata[16];
          s_next.rd_pend = 1'b1;
          s_next.st = arp_pkg::ARP_HS_LOW;
        end
        default:
          s_next.bresp = `ARP_AXI_SLVERR;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    // one link strobe in each of LOW and HIGH, none in IDLE; byte mode does low then high
    unique case (s_reg.st)
      arp_pkg::ARP_HS_IDLE:
        s_next.st = s_next.st;
      arp_pkg::ARP_HS_LOW:
      begin
        s_next.pin_data = s_reg.word_mode ? s_reg.word :
          {8'h00, s_reg.word[7:0]};
        s_next.wr = !s_reg.rd_pend;
        s_next.rd = s_reg.rd_pend;
        s_next.st = s_reg.word_mode ? arp_pkg::ARP_HS_IDLE :
          arp_pkg::ARP_HS_HIGH;
      end
      arp_pkg::ARP_HS_HIGH:
      begin
        s_next.pin_data = {7'h00, 1'b1, s_reg.word[15:8]};
        s_next.wr = !s_reg.rd_pend;
        s_next.rd = s_reg.rd_pend;
        s_next.st = arp_pkg::ARP_HS_IDLE;
      end
      default:
        s_next.st = arp_pkg::ARP_HS_IDLE;
    endcase
    if (s_reg.rd)
    begin
      if (s_reg.word_mode)
        s_next.last_read = link.data_to_host;
      else if (s_reg.pin_data[8])
      begin
        s_next.last_read[15:8] = link.data_to_host[7:0];
        s_next.rd_pend = 1'b0;
      end
      else
        s_next.last_read[7:0] = link.data_to_host[7:0];
      if (s_reg.word_mode)
        s_next.rd_pend = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.rvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `ARP_AXI_OKAY;
      unique case (s_axi_araddr)
        `ARP_HOST_STATUS:
          s_next.rdata = {31'h0, busy};
        `ARP_HOST_DATA:
          s_next.rdata = {16'h0, s_reg.last_read};
        default:
        begin
          s_next.rdata = 32'h0;
          s_next.rresp = `ARP_AXI_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (!aresetn)
      s_next = '0;
  end

  always_ff @(posedge aclk)
    s_reg <= s_next;

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign link.word_mode = s_reg.word_mode;
  assign link.data_from_host = s_reg.pin_data;
  assign link.wr_strobe = s_reg.wr;
  assign link.rd_strobe = s_reg.rd;
endmodule
`default_nettype wire

// ---- sim/arp_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module arp_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic word_mode,
  input wire logic [15:0] data_from_host,
  input wire logic [15:0] data_to_host,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic conv_start_pulse,
  input wire logic cal_start_pulse,
  input wire logic input_config_select,
  input wire logic [2:0] channel_select
);
  wire [15:0] d = data_from_host;
  logic [1:0] rsel_reg;
  logic [1:0] lo_reg;
  // ----------------------------------------
  // read select tracking
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rsel_reg <= 2'h0;
      lo_reg <= 2'h0;
    end
    else if (wr_strobe && word_mode && d[15:14] == 2'h3)
      rsel_reg <= d[7:6];
    else if (wr_strobe && !word_mode && !d[8])
      lo_reg <= d[7:6];
    else if (wr_strobe && !word_mode && d[7:6] == 2'h3)
      rsel_reg <= lo_reg;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_word_ctrl;
    wr_strobe && word_mode && d[15:14] == 2'h3;
  endsequence
  sequence s_byte_hi;
    wr_strobe && !word_mode && d[8];
  endsequence
  a_word_commit:
    assert property (s_word_ctrl |=> channel_select == $past(d[12:10])
      && input_config_select == $past(d[13])) else $error("word lost");
  a_byte_commit:
    assert property (s_byte_hi ##0 d[7:6] == 2'h3 |=>
      input_config_select == $past(d[5])) else $error("byte word lost");
  a_low_byte_hold:
    assert property (wr_strobe && !word_mode && !d[8] |=>
      $stable(channel_select)) else $error("low byte committed");
  a_addr_none:
    assert property (wr_strobe && word_mode && d[15:14] == 2'h0 |=>
      $stable(channel_select) && $stable(input_config_select))
      else $error("null word applied");
  a_conv_start:
    assert property (s_word_ctrl ##0 d[4] |-> ##[1:3] conv_start_pulse)
      else $error("no conversion start");
  a_cal_start:
    assert property (s_word_ctrl ##0 d[0] |-> ##[1:3] cal_start_pulse)
      else $error("no calibration start");
  a_pulse_cause:
    assert property (conv_start_pulse || cal_start_pulse |-> $past(wr_strobe)
      || $past(wr_strobe, 2) || $past(wr_strobe, 3))
      else $error("start without write");
  a_result_msb:
    assert property (word_mode && rsel_reg == 2'h0 && $past(rsel_reg) == 2'h0
      && $past(rsel_reg, 2) == 2'h0 |-> data_to_host[15:12] == 4'h0)
      else $error("result msbs set");
endmodule
`default_nettype wire

// ---- sim/adc_register_addressing_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_register_addressing_port_bench;
  logic aclk, aresetn = 0, sleep_n = 0, conv_done = 0, cal_done = 0;
  logic [11:0] conv_result = 0;
  logic [13:0] conv_status = 0;
  logic conv_start_pulse, cal_start_pulse, cal_type_select;
  logic input_config_select, analog_range_select;
  logic [1:0] cal_index, s_axi_bresp, s_axi_rresp;
  logic [2:0] channel_select, power_mode;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] r;
  logic [15:0] w;
  logic [13:0] ctrl = 0, test_v = 0, cal_v [4] = '{0, 0, 0, 0};
  int err_count, checks, cyc, conv_n, cal_n;
  arp_if u_arp_if();
  arp_device u_arp_device(.aclk, .aresetn, .link(u_arp_if), .sleep_n,
    .conv_result, .conv_status, .conv_done, .cal_done, .conv_start_pulse,
    .cal_start_pulse, .cal_type_select, .cal_index, .input_config_select,
    .channel_select, .analog_range_select, .power_mode);
  arp_host u_arp_host(.aclk, .aresetn, .link(u_arp_if), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  arp_properties u_arp_properties(.aclk, .aresetn,
    .word_mode(u_arp_if.word_mode), .data_from_host(u_arp_if.data_from_host),
    .data_to_host(u_arp_if.data_to_host), .wr_strobe(u_arp_if.wr_strobe),
    .rd_strobe(u_arp_if.rd_strobe), .conv_start_pulse, .cal_start_pulse,
    .input_config_select, .channel_select);
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    conv_n = conv_n + conv_start_pulse;
    cal_n = cal_n + cal_start_pulse;
    if (cyc == 60000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // checking and expectations
  // ----------------------------------------
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic [10:0] f_out(input logic [13:0] c, input logic s);
    return {c[13], c[12:10], c[5], c[3], c[2:1], c[9:8], s};
  endfunction
  function automatic logic [15:0] f_rd(input logic [13:0] c);
    case (c[7:6])
      2'h0: return {4'h0, conv_result};
      2'h1: return {2'h0, test_v};
      2'h2: return {2'h0, cal_v[c[2:1]]};
      default: return {2'h0, conv_status};
    endcase
  endfunction
  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // link transfer, then wait until idle
  task automatic op(input logic [3:0] a, input logic [16:0] v);
    axw(a, {15'h0, v});
    chk(r, 2'h0);
    do axr(4'h8); while (d[0]);
  endtask
  task automatic rdchk(input logic md);
    logic [15:0] m;
    m = (ctrl[7:6] == 2'h0) ? 16'hffff : 16'h3fff;
    op(4'h4, {md, 16'h0});
    axr(4'hc);
    chk(d[15:0] & m, f_rd(ctrl) & m);
  endtask
  task automatic wr(input logic m, input logic [15:0] v);
    op(4'h0, {m, v});
    case (v[15:14])
      2'h1: test_v = v[13:0];
      2'h2: if (!ctrl[0]) cal_v[ctrl[2:1]] = v[13:0];
      2'h3: ctrl = v[13:0];
      default: ;
    endcase
    chk({input_config_select, channel_select, analog_range_select,
      cal_type_select, cal_index, power_mode}, f_out(ctrl, sleep_n));
    rdchk(m);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(22));
    conv_result <= 12'hfff;
    rdchk(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      wr(1'(k), {2'h3, 6'h0, 2'h2, 3'h0, 2'(k), 1'b0});
      wr(~1'(k), {2'h2, 14'($urandom)});
    end
    wr(1'b1, 16'hc011);
    chk(conv_n, 32'd1);
    chk(cal_n, 32'd1);
    wr(1'b0, 16'h8123);
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    wr(1'b1, 16'hc0c0);
    axr(4'h2);
    chk(r, 2'h2);
    chk(d, 32'h0);
    axw(4'h6, 32'h0);
    chk(r, 2'h2);
    for (int i = 0; i < 40; i++)
    begin
      w = 16'($urandom);
      if (w[15] && w[14]) w = w & 16'hffee;
      sleep_n <= 1'($urandom);
      conv_result <= 12'($urandom);
      conv_status <= 14'($urandom);
      wr(1'($urandom), w);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
